// File: design/ift_pkg.sv
// Constants shared by the instruction fetch supervision timer files.
// Assumes byte addresses on an 8-bit address port and 16-bit register data.
package ift_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] OFF_CONTROL      = 8'h5C;
    localparam logic [7:0] OFF_PRECLEAR     = 8'h60;
    localparam logic [7:0] OFF_CLEAR        = 8'h64;
    localparam logic [7:0] OFF_STATUS       = 8'h68;
    localparam logic [7:0] OFF_COUNT_LOW    = 8'h6C;
    localparam logic [7:0] OFF_COUNT_HIGH   = 8'h6E;
    localparam logic [7:0] OFF_HOLD         = 8'h70;
    localparam logic [7:0] OFF_CFG_CNT_LOW  = 8'h74;
    localparam logic [7:0] OFF_CFG_CNT_HIGH = 8'h76;
    localparam logic [7:0] OFF_CFG_WIN_LOW  = 8'h78;
    localparam logic [7:0] OFF_CFG_WIN_HIGH = 8'h7A;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned CTRL_ON_BIT      = 15;
    localparam int unsigned PRECLEAR_LSB     = 8;
    localparam int unsigned STAT_BAD_PRE_BIT = 7;
    localparam int unsigned STAT_BAD_CLR_BIT = 6;
    localparam int unsigned STAT_EVENT_BIT   = 5;
    localparam int unsigned STAT_WINDOW_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Key values and reset values.
    localparam logic [7:0]  PRECLEAR_KEY  = 8'h40;
    localparam logic [7:0]  CLEAR_KEY     = 8'h08;
    localparam logic [7:0]  KEY_RESET     = 8'h00;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;

    // Sequence state of the two-step clear.
    typedef enum logic [0:0] {
        IFT_SEQ_IDLE  = 1'b0,
        IFT_SEQ_ARMED = 1'b1
    } ift_seq_state_t;

endpackage : ift_pkg

// File: design/ift_counter.sv
// Supervision counter: counts instruction fetches up to the match value.
// Assumes fetch and sleep inputs are synchronous to clock.
`timescale 1ns/1ns
module ift_counter (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        active,
    input  wire logic        fetch,
    input  wire logic        sleep,
    input  wire logic        clearCount,
    input  wire logic [31:0] matchValue,
    input  wire logic [31:0] windowValue,
    output logic      [31:0] count_q,
    output logic             expired_q,
    output logic             windowOpen_q
);

    logic [31:0] count_d;
    logic        atMatch;

    assign atMatch = (count_q == matchValue);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        count_d = count_q;
        if (clearCount) begin
            count_d = ift_pkg::COUNT_RESET;
        end else if (active && fetch && !sleep && !atMatch) begin
            count_d = count_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= ift_pkg::COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Expiry is only meaningful while the timer runs, so a stopped timer never flags.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            expired_q    <= 1'b0;
            windowOpen_q <= 1'b0;
        end else begin
            expired_q    <= active && (count_d == matchValue);
            windowOpen_q <= active && (count_d >= windowValue);
        end
    end

endmodule : ift_counter

// File: design/ift_clear_seq.sv
// Two-step clear sequence checker with its key fields and error flags.
// Assumes one-cycle write pulses decoded by the register block.
`timescale 1ns/1ns
module ift_clear_seq (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       preWrite,
    input  wire logic       clrWrite,
    input  wire logic [7:0] keyData,
    output logic      [7:0] preField_q,
    output logic      [7:0] clrField_q,
    output logic            clearOk,
    output logic            badPre,
    output logic            badClr
);

    ift_pkg::ift_seq_state_t state_q;

    assign badPre  = preWrite && (keyData != ift_pkg::PRECLEAR_KEY);
    assign clearOk = clrWrite && (keyData == ift_pkg::CLEAR_KEY)
                     && (state_q == ift_pkg::IFT_SEQ_ARMED);
    assign badClr  = clrWrite && !clearOk;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ift_pkg::IFT_SEQ_IDLE;
        end else begin
            case (state_q)
                ift_pkg::IFT_SEQ_IDLE: begin
                    if (preWrite && !badPre) begin
                        state_q <= ift_pkg::IFT_SEQ_ARMED;
                    end
                end
                ift_pkg::IFT_SEQ_ARMED: begin
                    if (clearOk || badPre) begin
                        state_q <= ift_pkg::IFT_SEQ_IDLE;
                    end
                end
                default: begin
                    state_q <= ift_pkg::IFT_SEQ_IDLE;
                end
            endcase
        end
    end

    // A wrong preclear value is kept in the field so software can see what it wrote.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            preField_q <= ift_pkg::KEY_RESET;
        end else if (clearOk) begin
            preField_q <= ift_pkg::KEY_RESET;
        end else if (preWrite) begin
            preField_q <= keyData;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clrField_q <= ift_pkg::KEY_RESET;
        end else if (clearOk) begin
            clrField_q <= ift_pkg::KEY_RESET;
        end else if (clrWrite) begin
            clrField_q <= keyData;
        end
    end

endmodule : ift_clear_seq

// File: design/ift_supervisor.sv
// Top of the instruction fetch supervision timer: register port, flags, snapshot.
// Assumes a master that issues one-cycle strobes, never both at once, and
// fuse values that stay constant while the timer runs.
//
// Operation
// - The counter runs on the system clock and adds one per instruction fetch until it equals the match value.
// - No counting happens while the processor sleeps.
// - The timer runs when the fuse enable is set or when software sets the control enable bit.
// - The counter is 32 bits and its match value joins the low and high 16-bit fuse words.
// - The clear window value joins the low and high 16-bit window fuse words.
// - The software enable bit counts only while the configuration disable setting is zero.
// - Writing 0x40 to the preclear field in bits 15:8 completes step one.
// - Any other preclear value sets the bad preclear flag.
// - A reset of the timer zeroes the preclear field.
// - A correct clear after a valid step one also zeroes the preclear field.
// - The timer raises an event toward the processor to report a software fault.
// - Writing 0x08 to the clear field after step one zeroes both key fields and the counter.
// - Any other clear value sets the bad clear flag, keeps the preclear field and stores the value.
// - The event flag is set on counter expiry or on a wrong key value.
// - The hold register resets to zero and loads the upper half only after both halves are read.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module ift_supervisor (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdData,
    input  wire logic        fetchStrobe,
    input  wire logic        sleepMode,
    input  wire logic        fuseEnable,
    input  wire logic        configDisableSetting,
    input  wire logic [15:0] matchValueLowFuse,
    input  wire logic [15:0] matchValueHighFuse,
    input  wire logic [15:0] windowIntervalLowFuse,
    input  wire logic [15:0] windowIntervalHighFuse,
    output logic             eventStatusFlag,
    output logic             clearWindowOpenFlag,
    output logic             timerActive
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic wrControl;
    logic wrPreclear;
    logic wrClear;
    logic wrStatus;
    logic rdCountLow;
    logic rdCountHigh;

    assign wrControl   = regWrite && (regAddr == ift_pkg::OFF_CONTROL);
    assign wrPreclear  = regWrite && (regAddr == ift_pkg::OFF_PRECLEAR);
    assign wrClear     = regWrite && (regAddr == ift_pkg::OFF_CLEAR);
    assign wrStatus    = regWrite && (regAddr == ift_pkg::OFF_STATUS);
    assign rdCountLow  = regRead && (regAddr == ift_pkg::OFF_COUNT_LOW);
    assign rdCountHigh = regRead && (regAddr == ift_pkg::OFF_COUNT_HIGH);

    ////////////////////////////////////////////////////////////////////////////
    // Control register and enable.

    logic        swOn_q;
    logic        active;
    logic [31:0] matchValue;
    logic [31:0] windowValue;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            swOn_q <= 1'b0;
        end else if (wrControl) begin
            swOn_q <= regWrData[ift_pkg::CTRL_ON_BIT];
        end
    end

    // The software bit is stored even while it has no effect, so it reads back as written.
    assign active = fuseEnable || (swOn_q && !configDisableSetting);

    assign matchValue  = {matchValueHighFuse, matchValueLowFuse};
    assign windowValue = {windowIntervalHighFuse, windowIntervalLowFuse};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timerActive <= 1'b0;
        end else begin
            timerActive <= active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear sequence and counter.

    logic [7:0]  preField;
    logic [7:0]  clrField;
    logic        clearOk;
    logic        badPre;
    logic        badClr;
    logic [7:0]  keyData;
    logic [31:0] count;
    logic        expired;
    logic        windowOpen;

    // The preclear key sits in the high byte, the clear key in the low byte.
    assign keyData = wrPreclear ? regWrData[15:ift_pkg::PRECLEAR_LSB] : regWrData[7:0];

    ift_clear_seq u_seq (
        .clock      (clock),
        .arst_n     (arst_n),
        .preWrite   (wrPreclear),
        .clrWrite   (wrClear),
        .keyData    (keyData),
        .preField_q (preField),
        .clrField_q (clrField),
        .clearOk    (clearOk),
        .badPre     (badPre),
        .badClr     (badClr)
    );

    ift_counter u_cnt (
        .clock        (clock),
        .arst_n       (arst_n),
        .active       (active),
        .fetch        (fetchStrobe),
        .sleep        (sleepMode),
        .clearCount   (clearOk),
        .matchValue   (matchValue),
        .windowValue  (windowValue),
        .count_q      (count),
        .expired_q    (expired),
        .windowOpen_q (windowOpen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status flags. Software clears a flag by writing zero to it;
    // a hardware set in the same cycle wins over that clear.

    logic badPreFlag_q;
    logic badClrFlag_q;
    logic eventFlag_q;
    logic eventSet;

    assign eventSet = expired || badPre || badClr;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            badPreFlag_q <= 1'b0;
        end else if (badPre) begin
            badPreFlag_q <= 1'b1;
        end else if (wrStatus) begin
            badPreFlag_q <= regWrData[ift_pkg::STAT_BAD_PRE_BIT];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            badClrFlag_q <= 1'b0;
        end else if (badClr) begin
            badClrFlag_q <= 1'b1;
        end else if (wrStatus) begin
            badClrFlag_q <= regWrData[ift_pkg::STAT_BAD_CLR_BIT];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eventFlag_q <= 1'b0;
        end else if (eventSet) begin
            eventFlag_q <= 1'b1;
        end else if (wrStatus) begin
            eventFlag_q <= regWrData[ift_pkg::STAT_EVENT_BIT];
        end
    end

    // The event line toward the processor follows the sticky flag one cycle later.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eventStatusFlag     <= 1'b0;
            clearWindowOpenFlag <= 1'b0;
        end else begin
            eventStatusFlag     <= eventFlag_q;
            clearWindowOpenFlag <= windowOpen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Upper count snapshot. Reading the low half captures the upper half;
    // the hold register takes it only when the high half is read next, so
    // the low read and a later hold read form a coherent 32-bit value.

    logic        lowRead_q;
    logic [15:0] pendingHigh_q;
    logic [15:0] holdReg_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lowRead_q     <= 1'b0;
            pendingHigh_q <= ift_pkg::REG_RESET;
        end else if (rdCountLow) begin
            lowRead_q     <= 1'b1;
            pendingHigh_q <= count[31:16];
        end else if (rdCountHigh) begin
            lowRead_q     <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            holdReg_q <= ift_pkg::REG_RESET;
        end else if (rdCountHigh && lowRead_q) begin
            holdReg_q <= pendingHigh_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data: valid only in the cycle after the read strobe, zero otherwise
    // and zero for unmapped offsets.

    logic [15:0] rdMux;
    logic [15:0] statusWord;

    always_comb begin
        statusWord = ift_pkg::REG_RESET;
        statusWord[ift_pkg::STAT_BAD_PRE_BIT] = badPreFlag_q;
        statusWord[ift_pkg::STAT_BAD_CLR_BIT] = badClrFlag_q;
        statusWord[ift_pkg::STAT_EVENT_BIT]   = eventFlag_q;
        statusWord[ift_pkg::STAT_WINDOW_BIT]  = windowOpen;
    end

    always_comb begin
        rdMux = ift_pkg::REG_RESET;
        case (regAddr)
            ift_pkg::OFF_CONTROL: begin
                rdMux[ift_pkg::CTRL_ON_BIT] = swOn_q;
            end
            ift_pkg::OFF_PRECLEAR: begin
                rdMux = {preField, 8'h00};
            end
            ift_pkg::OFF_CLEAR: begin
                rdMux = {8'h00, clrField};
            end
            ift_pkg::OFF_STATUS: begin
                rdMux = statusWord;
            end
            ift_pkg::OFF_COUNT_LOW: begin
                rdMux = count[15:0];
            end
            ift_pkg::OFF_COUNT_HIGH: begin
                rdMux = count[31:16];
            end
            ift_pkg::OFF_HOLD: begin
                rdMux = holdReg_q;
            end
            ift_pkg::OFF_CFG_CNT_LOW: begin
                rdMux = matchValueLowFuse;
            end
            ift_pkg::OFF_CFG_CNT_HIGH: begin
                rdMux = matchValueHighFuse;
            end
            ift_pkg::OFF_CFG_WIN_LOW: begin
                rdMux = windowIntervalLowFuse;
            end
            ift_pkg::OFF_CFG_WIN_HIGH: begin
                rdMux = windowIntervalHighFuse;
            end
            default: begin
                rdMux = ift_pkg::REG_RESET;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= ift_pkg::REG_RESET;
        end else if (regRead) begin
            regRdData <= rdMux;
        end else begin
            regRdData <= ift_pkg::REG_RESET;
        end
    end

endmodule : ift_supervisor

// File: bench/ift_supervisor_chk.sv
// Port-level assertions and covers for the supervision timer top.
// Assumes it is bound to ift_supervisor and sees only that module's ports.
`timescale 1ns/1ns
module ift_supervisor_chk (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdData,
    input wire logic        fetchStrobe,
    input wire logic        sleepMode,
    input wire logic        fuseEnable,
    input wire logic        configDisableSetting,
    input wire logic [15:0] matchValueLowFuse,
    input wire logic [15:0] matchValueHighFuse,
    input wire logic [15:0] windowIntervalLowFuse,
    input wire logic [15:0] windowIntervalHighFuse,
    input wire logic        eventStatusFlag,
    input wire logic        clearWindowOpenFlag,
    input wire logic        timerActive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////
    cfg_count_a: assert property (regRead && regAddr == ift_pkg::OFF_CFG_CNT_LOW
        |=> regRdData == $past(matchValueLowFuse)) else $error("configured count read wrong");
    cfg_window_a: assert property (regRead && regAddr == ift_pkg::OFF_CFG_WIN_HIGH
        |=> regRdData == $past(windowIntervalHighFuse)) else $error("configured window read wrong");
    fuse_active_a: assert property ($past(fuseEnable) && $past(arst_n) |-> timerActive)
        else $error("fuse enable did not activate timer");
    event_sticky_a: assert property (eventStatusFlag
        && !$past(regWrite && regAddr == ift_pkg::OFF_STATUS) |=> eventStatusFlag)
        else $error("event flag dropped without a status write");
    event_set_a: assert property (regWrite && regAddr == ift_pkg::OFF_STATUS && regWrData[5]
        |-> ##2 eventStatusFlag) else $error("status write did not set event flag");
    bad_pre_a: assert property (regWrite && regAddr == ift_pkg::OFF_PRECLEAR
        && regWrData[15:8] != ift_pkg::PRECLEAR_KEY |-> ##[1:4] eventStatusFlag)
        else $error("bad preclear value raised no event");
    bad_clr_a: assert property (regWrite && regAddr == ift_pkg::OFF_CLEAR
        && regWrData[7:0] != ift_pkg::CLEAR_KEY |-> ##[1:4] eventStatusFlag)
        else $error("bad clear value raised no event");
    window_idle_a: assert property (!timerActive [*4] |-> !clearWindowOpenFlag)
        else $error("clear window open while timer idle");
    read_idle_a: assert property (!$past(regRead) |-> regRdData == 16'h0000)
        else $error("read data outside the read answer cycle");
    unmapped_a: assert property (regRead && regAddr == 8'h00 |=> regRdData == 16'h0000)
        else $error("unmapped read returned data");
    clear_seen_c: cover property (regWrite && regAddr == ift_pkg::OFF_CLEAR && regWrData[7:0] == 8'h08);
    event_rise_c: cover property ($rose(eventStatusFlag));
    window_rise_c: cover property ($rose(clearWindowOpenFlag));
endmodule : ift_supervisor_chk

bind ift_supervisor ift_supervisor_chk ift_supervisor_chk_i (
    .clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .fetchStrobe(fetchStrobe), .sleepMode(sleepMode), .fuseEnable(fuseEnable),
    .configDisableSetting(configDisableSetting), .matchValueLowFuse(matchValueLowFuse),
    .matchValueHighFuse(matchValueHighFuse), .windowIntervalLowFuse(windowIntervalLowFuse),
    .windowIntervalHighFuse(windowIntervalHighFuse), .eventStatusFlag(eventStatusFlag),
    .clearWindowOpenFlag(clearWindowOpenFlag), .timerActive(timerActive));

// File: bench/ift_supervisor_tb.sv
// Self-checking bench for the supervision timer: register tasks and scenarios.
// Assumes the checker is bound separately; match 0x0001_0003, window 0x0000_0100.
`timescale 1ns/1ns
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp); end end
module ift_supervisor_tb;
    logic        clock    = 1'b0;
    logic        arst_n   = 1'b0;
    logic [7:0]  regAddr  = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrite = 1'b0;
    logic        regRead  = 1'b0;
    logic [15:0] regRdData;
    logic        fetchStrobe = 1'b0;
    logic        sleepMode   = 1'b0;
    logic        fuseEnable  = 1'b0;
    logic        configDisableSetting = 1'b0;
    logic        eventStatusFlag;
    logic        clearWindowOpenFlag;
    logic        timerActive;
    int          n_fail   = 0;
    int          compares = 0;
    always #50 clock = ~clock;
    ift_supervisor ift_supervisor_i (
        .clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .fetchStrobe(fetchStrobe), .sleepMode(sleepMode), .fuseEnable(fuseEnable),
        .configDisableSetting(configDisableSetting), .matchValueLowFuse(16'h0003),
        .matchValueHighFuse(16'h0001), .windowIntervalLowFuse(16'h0100),
        .windowIntervalHighFuse(16'h0000), .eventStatusFlag(eventStatusFlag),
        .clearWindowOpenFlag(clearWindowOpenFlag), .timerActive(timerActive));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        `CHK(regRdData, e)
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle
    // Holds the fetch line for exactly n sampling edges.
    task automatic fetch(input int n);
        @(posedge clock);
        fetchStrobe <= 1'b1;
        repeat (n) @(posedge clock);
        fetchStrobe <= 1'b0;
    endtask : fetch
    task automatic report_and_stop;
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100_000 * 100);
        n_fail++;
        report_and_stop();
    end
    initial begin
        logic [7:0] zeroAddr [8];
        zeroAddr = '{ift_pkg::OFF_CONTROL, ift_pkg::OFF_PRECLEAR, ift_pkg::OFF_CLEAR, ift_pkg::OFF_STATUS,
                     ift_pkg::OFF_COUNT_LOW, ift_pkg::OFF_COUNT_HIGH, ift_pkg::OFF_HOLD, 8'h00};
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        foreach (zeroAddr[i]) rd(zeroAddr[i], 16'h0000);
        rd(ift_pkg::OFF_CFG_CNT_LOW, 16'h0003);
        rd(ift_pkg::OFF_CFG_CNT_HIGH, 16'h0001);
        rd(ift_pkg::OFF_CFG_WIN_LOW, 16'h0100);
        rd(ift_pkg::OFF_CFG_WIN_HIGH, 16'h0000);
        wr(ift_pkg::OFF_CONTROL, 16'h8000);
        rd(ift_pkg::OFF_CONTROL, 16'h8000);
        idle(3);
        `CHK(timerActive, 1'b1)
        fetch(5);
        rd(ift_pkg::OFF_COUNT_LOW, 16'h0005);
        @(posedge clock);
        sleepMode <= 1'b1;
        fetch(5);
        sleepMode <= 1'b0;
        rd(ift_pkg::OFF_COUNT_LOW, 16'h0005);
        @(posedge clock);
        configDisableSetting <= 1'b1;
        idle(3);
        `CHK(timerActive, 1'b0)
        fetch(3);
        rd(ift_pkg::OFF_COUNT_LOW, 16'h0005);
        @(posedge clock);
        fuseEnable <= 1'b1;
        idle(2);
        fetch(2);
        rd(ift_pkg::OFF_COUNT_LOW, 16'h0007);
        @(posedge clock);
        fuseEnable <= 1'b0;
        configDisableSetting <= 1'b0;
        `CHK(clearWindowOpenFlag, 1'b0)
        // Runs past the match value to show the count stops there.
        fetch(65560);
        idle(4);
        `CHK(eventStatusFlag, 1'b1)
        `CHK(clearWindowOpenFlag, 1'b1)
        rd(ift_pkg::OFF_STATUS, 16'h0021);
        rd(ift_pkg::OFF_COUNT_HIGH, 16'h0001);
        rd(ift_pkg::OFF_HOLD, 16'h0000);
        rd(ift_pkg::OFF_COUNT_LOW, 16'h0003);
        rd(ift_pkg::OFF_COUNT_HIGH, 16'h0001);
        rd(ift_pkg::OFF_HOLD, 16'h0001);
        // Expiry stays asserted while the count sits at the match value, so it beats this clear.
        wr(ift_pkg::OFF_STATUS, 16'h0000);
        idle(3);
        `CHK(eventStatusFlag, 1'b1)
        wr(ift_pkg::OFF_PRECLEAR, 16'h4000);
        rd(ift_pkg::OFF_PRECLEAR, 16'h4000);
        rd(ift_pkg::OFF_STATUS, 16'h0021);
        wr(ift_pkg::OFF_CLEAR, 16'h0008);
        rd(ift_pkg::OFF_COUNT_LOW, 16'h0000);
        rd(ift_pkg::OFF_COUNT_HIGH, 16'h0000);
        rd(ift_pkg::OFF_PRECLEAR, 16'h0000);
        rd(ift_pkg::OFF_CLEAR, 16'h0000);
        rd(ift_pkg::OFF_STATUS, 16'h0020);
        // With the counter restarted the sticky event can now be cleared.
        wr(ift_pkg::OFF_STATUS, 16'h0000);
        idle(3);
        `CHK(eventStatusFlag, 1'b0)
        wr(ift_pkg::OFF_PRECLEAR, 16'h1200);
        rd(ift_pkg::OFF_PRECLEAR, 16'h1200);
        rd(ift_pkg::OFF_STATUS, 16'h00A0);
        wr(ift_pkg::OFF_CLEAR, 16'h0008);
        rd(ift_pkg::OFF_CLEAR, 16'h0008);
        rd(ift_pkg::OFF_PRECLEAR, 16'h1200);
        rd(ift_pkg::OFF_STATUS, 16'h00E0);
        wr(ift_pkg::OFF_STATUS, 16'h0000);
        wr(ift_pkg::OFF_PRECLEAR, 16'h4000);
        wr(ift_pkg::OFF_CLEAR, 16'h0055);
        rd(ift_pkg::OFF_CLEAR, 16'h0055);
        rd(ift_pkg::OFF_PRECLEAR, 16'h4000);
        rd(ift_pkg::OFF_STATUS, 16'h0060);
        wr(ift_pkg::OFF_STATUS, 16'h0000);
        wr(ift_pkg::OFF_STATUS, 16'h0020);
        rd(ift_pkg::OFF_STATUS, 16'h0020);
        wr(ift_pkg::OFF_PRECLEAR, 16'h4000);
        fetch(3);
        @(posedge clock);
        arst_n <= 1'b0;
        idle(2);
        arst_n <= 1'b1;
        foreach (zeroAddr[i]) rd(zeroAddr[i], 16'h0000);
        report_and_stop();
    end
endmodule : ift_supervisor_tb
